//--- include/acc_ops_pkg.sv
package acc_ops_pkg;
   // operation codes presented by the sequencer
   localparam logic [3:0] OP_LOAD_WIDE = 4'h0;
   localparam logic [3:0] OP_OUT_FULL = 4'h1;
   localparam logic [3:0] OP_OUT_BYTE = 4'h2;
   localparam logic [3:0] OP_OUT_HNIB = 4'h3;
   localparam logic [3:0] OP_OUT_LNIB = 4'h4;
   localparam logic [3:0] OP_OUT_WIDE = 4'h5;
   localparam logic [3:0] OP_CMP = 4'h6;
   localparam logic [3:0] OP_ADD = 4'h7;
   localparam logic [3:0] OP_SUB = 4'h8;
   localparam logic [3:0] OP_MUL = 4'h9;
   // kind of reference named by the instruction
   localparam logic [2:0] KIND_OUTPUT = 3'h0;
   localparam logic [2:0] KIND_IR = 3'h1;
   localparam logic [2:0] KIND_SR = 3'h2;
   localparam logic [2:0] KIND_DR = 3'h3;
   localparam logic [2:0] KIND_TC = 3'h4;
   localparam logic [2:0] KIND_HD_OUT = 3'h5;
   localparam logic [2:0] KIND_HD_IN = 3'h6;
   localparam logic [2:0] KIND_CONST = 3'h7;
   // coil and register numbers in the controller's reference space
   localparam logic [9:0] COIL_GT_NUM = 10'd772;
   localparam logic [9:0] COIL_LT_NUM = 10'd774;
   localparam logic [9:0] COIL_EQ_NUM = 10'd777;
   localparam logic [9:0] AUX_LO_NUM = 10'd576;
   localparam logic [9:0] AUX_HI_NUM = 10'd577;
   // write strobes, one per byte
   localparam logic [1:0] STRB_NONE = 2'h0;
   localparam logic [1:0] STRB_LOW = 2'h1;
   localparam logic [1:0] STRB_BOTH = 2'h3;
   // reset value and index of the last multiplier digit
   localparam logic [15:0] ACC_RST = 16'h0000;
   localparam logic [1:0] LAST_DIGIT = 2'h3;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_ADD = 3'b100
   } state_e;
endpackage : acc_ops_pkg

//--- hdl/accumulator_data_ops.sv
`timescale 1ns/100ps
`default_nettype none
module accumulator_data_ops (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic start_i,
   input wire logic [3:0] op_i,
   input wire logic [2:0] kind_i,
   input wire logic [15:0] operand_i,
   input wire logic [7:0] dest_byte_i,
   output logic [15:0] acc_o,
   output logic [15:0] aux_acc_o,
   output logic wr_en_o,
   output logic [15:0] wr_data_o,
   output logic [1:0] wr_strb_o,
   output logic coil_gt_o,
   output logic coil_lt_o,
   output logic coil_eq_o,
   output logic busy_o,
   output logic done_o,
   output logic err_o
);
   function automatic logic [32:0] bcd_add(input logic [31:0] a, input logic [31:0] b, input logic cin);
      logic [4:0] d;
      logic c;
      logic [31:0] s;
      c = cin;
      s = 32'h0;
      d = 5'h00;
      for (int i = 0; i < 8; i++) begin
         d = {1'b0, a[4*i+:4]} + {1'b0, b[4*i+:4]} + {4'h0, c};
         c = (d > 5'h09);
         s[4*i+:4] = c ? 4'(d + 5'h06) : d[3:0];
      end
      return {c, s};
   endfunction : bcd_add

   function automatic logic bcd_valid(input logic [15:0] x);
      logic v;
      v = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (x[4*i+:4] > 4'h9) begin
            v = 1'b0;
         end
      end
      return v;
   endfunction : bcd_valid

   function automatic logic [15:0] nines(input logic [15:0] x);
      logic [15:0] r;
      r = 16'h0;
      for (int i = 0; i < 4; i++) begin
         r[4*i+:4] = 4'h9 - x[4*i+:4];
      end
      return r;
   endfunction : nines

   acc_ops_pkg::state_e state;
   logic [15:0] acc;
   logic [15:0] mplier;
   logic [31:0] prod;
   logic [1:0] dig;
   logic [3:0] reps;

   wire take = start_i && (state == acc_ops_pkg::ST_IDLE);
   wire kind_small = (kind_i == acc_ops_pkg::KIND_OUTPUT) || (kind_i == acc_ops_pkg::KIND_IR) ||
                     (kind_i == acc_ops_pkg::KIND_SR) || (kind_i == acc_ops_pkg::KIND_DR);
   wire kind_full = kind_small || (kind_i == acc_ops_pkg::KIND_TC);
   wire kind_hd_in = (kind_i == acc_ops_pkg::KIND_HD_IN);
   wire kind_hd_out = (kind_i == acc_ops_pkg::KIND_HD_OUT);
   // a bad operand leaves the accumulator untouched rather than storing garbage digits
   wire bcd_ok = bcd_valid(acc) && bcd_valid(operand_i);
   wire [32:0] sum_w = bcd_add({16'h0000, acc}, {16'h0000, operand_i}, 1'b0);
   wire [32:0] diff_w = bcd_add({16'h0000, acc}, {16'h0000, nines(operand_i)}, 1'b1);
   wire [32:0] macc_w = bcd_add(prod, {16'h0000, acc}, 1'b0);
   wire sum_ovf = (sum_w[19:16] != 4'h0);
   // no carry into the fifth digit means the result went below zero
   wire diff_borrow = ~diff_w[16];
   wire [7:0] hnib_byte = {acc[3:0], dest_byte_i[3:0]};
   wire [7:0] lnib_byte = {dest_byte_i[7:4], acc[3:0]};

   assign acc_o = acc;

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state <= acc_ops_pkg::ST_IDLE;
         acc <= acc_ops_pkg::ACC_RST;
         aux_acc_o <= acc_ops_pkg::ACC_RST;
         mplier <= acc_ops_pkg::ACC_RST;
         prod <= 32'h0;
         dig <= 2'h0;
         reps <= 4'h0;
         wr_en_o <= 1'b0;
         wr_data_o <= 16'h0000;
         wr_strb_o <= acc_ops_pkg::STRB_NONE;
         coil_gt_o <= 1'b0;
         coil_lt_o <= 1'b0;
         coil_eq_o <= 1'b0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         err_o <= 1'b0;
      end else begin
         wr_en_o <= 1'b0;
         wr_strb_o <= acc_ops_pkg::STRB_NONE;
         done_o <= 1'b0;
         err_o <= 1'b0;
         unique case (state)
            acc_ops_pkg::ST_IDLE: begin
               if (take) begin
                  done_o <= (op_i != acc_ops_pkg::OP_MUL) || !bcd_ok;
                  unique case (op_i)
                     acc_ops_pkg::OP_LOAD_WIDE: begin
                        if (kind_hd_in) begin
                           acc <= operand_i;
                        end else begin
                           err_o <= 1'b1;
                        end
                     end
                     acc_ops_pkg::OP_OUT_FULL: begin
                        wr_en_o <= kind_full;
                        wr_strb_o <= kind_full ? acc_ops_pkg::STRB_BOTH : acc_ops_pkg::STRB_NONE;
                        wr_data_o <= acc;
                        err_o <= !kind_full;
                     end
                     acc_ops_pkg::OP_OUT_BYTE: begin
                        wr_en_o <= kind_small;
                        wr_strb_o <= kind_small ? acc_ops_pkg::STRB_LOW : acc_ops_pkg::STRB_NONE;
                        wr_data_o <= {8'h00, acc[7:0]};
                        err_o <= !kind_small;
                     end
                     acc_ops_pkg::OP_OUT_HNIB: begin
                        wr_en_o <= kind_small;
                        wr_strb_o <= kind_small ? acc_ops_pkg::STRB_LOW : acc_ops_pkg::STRB_NONE;
                        wr_data_o <= {8'h00, hnib_byte};
                        err_o <= !kind_small;
                     end
                     acc_ops_pkg::OP_OUT_LNIB: begin
                        wr_en_o <= kind_small;
                        wr_strb_o <= kind_small ? acc_ops_pkg::STRB_LOW : acc_ops_pkg::STRB_NONE;
                        wr_data_o <= {8'h00, lnib_byte};
                        err_o <= !kind_small;
                     end
                     acc_ops_pkg::OP_OUT_WIDE: begin
                        wr_en_o <= kind_hd_out;
                        wr_strb_o <= kind_hd_out ? acc_ops_pkg::STRB_BOTH : acc_ops_pkg::STRB_NONE;
                        wr_data_o <= acc;
                        err_o <= !kind_hd_out;
                     end
                     acc_ops_pkg::OP_CMP: begin
                        // packed BCD orders like binary, so one unsigned compare serves both
                        coil_gt_o <= (acc > operand_i);
                        coil_lt_o <= (acc < operand_i);
                        coil_eq_o <= (acc == operand_i);
                     end
                     acc_ops_pkg::OP_ADD: begin
                        if (bcd_ok) begin
                           acc <= sum_w[15:0];
                        end
                        err_o <= !bcd_ok || sum_ovf;
                     end
                     acc_ops_pkg::OP_SUB: begin
                        if (bcd_ok) begin
                           acc <= diff_w[15:0];
                        end
                        err_o <= !bcd_ok || diff_borrow;
                     end
                     acc_ops_pkg::OP_MUL: begin
                        if (bcd_ok) begin
                           mplier <= operand_i;
                           prod <= 32'h0;
                           dig <= 2'h0;
                           busy_o <= 1'b1;
                           state <= acc_ops_pkg::ST_SHIFT;
                        end else begin
                           err_o <= 1'b1;
                        end
                     end
                     default: begin
                        err_o <= 1'b1;
                     end
                  endcase
               end
            end
            acc_ops_pkg::ST_SHIFT: begin
               // one decimal shift per multiplier digit, most significant first
               prod <= {prod[27:0], 4'h0};
               reps <= mplier[15:12];
               mplier <= {mplier[11:0], 4'h0};
               state <= acc_ops_pkg::ST_ADD;
            end
            acc_ops_pkg::ST_ADD: begin
               if (reps != 4'h0) begin
                  prod <= macc_w[31:0];
                  reps <= 4'(reps - 4'h1);
               end else if (dig == acc_ops_pkg::LAST_DIGIT) begin
                  acc <= prod[15:0];
                  aux_acc_o <= prod[31:16];
                  busy_o <= 1'b0;
                  done_o <= 1'b1;
                  state <= acc_ops_pkg::ST_IDLE;
               end else begin
                  dig <= 2'(dig + 2'h1);
                  state <= acc_ops_pkg::ST_SHIFT;
               end
            end
         endcase
      end
   end

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);

   load_wide_a: assert property (take && op_i == acc_ops_pkg::OP_LOAD_WIDE && kind_hd_in
      |=> acc_o == $past(operand_i) && done_o && !err_o) else $error("wide load wrong");
   out_full_a: assert property (take && op_i == acc_ops_pkg::OP_OUT_FULL && kind_full
      |=> wr_en_o && wr_strb_o == acc_ops_pkg::STRB_BOTH && wr_data_o == $past(acc)) else $error("full out wrong");
   out_byte_a: assert property (take && op_i == acc_ops_pkg::OP_OUT_BYTE && kind_small
      |=> wr_en_o && wr_strb_o == acc_ops_pkg::STRB_LOW && wr_data_o[7:0] == $past(acc[7:0])) else $error("byte out");
   high_nibble_a: assert property (take && op_i == acc_ops_pkg::OP_OUT_HNIB && kind_small
      |=> wr_data_o[7:4] == $past(acc[3:0]) && wr_data_o[3:0] == $past(dest_byte_i[3:0])) else $error("hnib out");
   low_nibble_a: assert property (take && op_i == acc_ops_pkg::OP_OUT_LNIB && kind_small
      |=> wr_data_o[3:0] == $past(acc[3:0]) && wr_data_o[7:4] == $past(dest_byte_i[7:4])) else $error("lnib out");
   wide_out_a: assert property (take && op_i == acc_ops_pkg::OP_OUT_WIDE
      |=> wr_en_o == $past(kind_hd_out) && err_o == !$past(kind_hd_out)) else $error("wide out kind");
   compare_a: assert property (take && op_i == acc_ops_pkg::OP_CMP |=> $onehot({coil_gt_o, coil_lt_o, coil_eq_o})
      && coil_gt_o == ($past(acc) > $past(operand_i)) && coil_lt_o == ($past(acc) < $past(operand_i)))
      else $error("compare coils");
   bcd_add_a: assert property (take && op_i == acc_ops_pkg::OP_ADD && bcd_ok
      |=> acc_o == $past(sum_w[15:0]) && err_o == $past(sum_ovf)) else $error("bcd add");
   bcd_sub_a: assert property (take && op_i == acc_ops_pkg::OP_SUB && bcd_ok
      |=> acc_o == $past(diff_w[15:0]) && bcd_valid(acc_o)) else $error("bcd sub");
   mul_done_a: assert property (take && op_i == acc_ops_pkg::OP_MUL && bcd_ok
      |=> busy_o [*1] ##[1:50] done_o && !busy_o && bcd_valid(aux_acc_o)) else $error("mul not done");
   bad_bcd_a: assert property (take && (op_i == acc_ops_pkg::OP_ADD || op_i == acc_ops_pkg::OP_MUL)
      && !bcd_ok |=> err_o && done_o && $stable(acc_o)) else $error("bad bcd kept");

   // a refused kind must leave the far side untouched, a stray strobe would corrupt a reference
   load_refuse_a: assert property (take && op_i == acc_ops_pkg::OP_LOAD_WIDE && !kind_hd_in
      |=> err_o && done_o && $stable(acc_o))
      else $error("wide load not refused");
   full_refuse_a: assert property (take && op_i == acc_ops_pkg::OP_OUT_FULL && !kind_full
      |=> !wr_en_o && wr_strb_o == acc_ops_pkg::STRB_NONE && err_o)
      else $error("full out not refused");
   byte_refuse_a: assert property (take && !kind_small && (op_i == acc_ops_pkg::OP_OUT_BYTE ||
      op_i == acc_ops_pkg::OP_OUT_HNIB || op_i == acc_ops_pkg::OP_OUT_LNIB) |=> !wr_en_o && err_o && done_o)
      else $error("byte out not refused");
   nib_strobe_a: assert property (take && (op_i == acc_ops_pkg::OP_OUT_HNIB || op_i == acc_ops_pkg::OP_OUT_LNIB)
      && kind_small |=> wr_en_o && wr_strb_o == acc_ops_pkg::STRB_LOW && done_o && !err_o)
      else $error("nibble strobe wrong");
   wide_data_a: assert property (take && op_i == acc_ops_pkg::OP_OUT_WIDE && kind_hd_out
      |=> wr_strb_o == acc_ops_pkg::STRB_BOTH && wr_data_o == $past(acc))
      else $error("wide out data wrong");
   strobe_pair_a: assert property (wr_en_o == (wr_strb_o != acc_ops_pkg::STRB_NONE))
      else $error("strobe without write");
   coil_hold_a: assert property (!(take && op_i == acc_ops_pkg::OP_CMP)
      |=> $stable({coil_gt_o, coil_lt_o, coil_eq_o}))
      else $error("coils moved without compare");
   cmp_quiet_a: assert property (take && op_i == acc_ops_pkg::OP_CMP
      |=> done_o && !err_o && !wr_en_o && $stable(acc_o))
      else $error("compare side effect");
   // packed bcd orders like binary, so a borrow is simply the accumulator below the operand
   sub_borrow_a: assert property (take && op_i == acc_ops_pkg::OP_SUB && bcd_ok
      |=> err_o == ($past(acc) < $past(operand_i)) && done_o)
      else $error("borrow flag wrong");
   add_valid_a: assert property (take && op_i == acc_ops_pkg::OP_ADD && bcd_ok
      |=> done_o && bcd_valid(acc_o))
      else $error("bcd sum invalid");
   mul_start_a: assert property (take && op_i == acc_ops_pkg::OP_MUL && bcd_ok
      |=> busy_o && !done_o && !err_o)
      else $error("multiply did not start");
   // the multiplicand is read every add cycle, so the accumulator must stay frozen until the end
   mul_quiet_a: assert property (busy_o
      |-> $stable(acc_o) && !wr_en_o && !err_o)
      else $error("accumulator moved in multiply");
   aux_hold_a: assert property (!busy_o
      |=> $stable(aux_acc_o))
      else $error("aux changed outside multiply");
   err_done_a: assert property (err_o |-> done_o)
      else $error("error without done");
   unknown_op_a: assert property (take && op_i > acc_ops_pkg::OP_MUL
      |=> err_o && done_o && !wr_en_o && $stable(acc_o))
      else $error("unknown opcode accepted");

   cov_mul_c: cover property (take && op_i == acc_ops_pkg::OP_MUL ##[1:50] done_o);
   cov_sub_borrow_c: cover property (take && op_i == acc_ops_pkg::OP_SUB && bcd_ok && diff_borrow);
   cov_eq_c: cover property (take && op_i == acc_ops_pkg::OP_CMP ##1 coil_eq_o);
   cov_wide_c: cover property (take && op_i == acc_ops_pkg::OP_OUT_WIDE ##1 wr_en_o);
   cov_tc_c: cover property (take && op_i == acc_ops_pkg::OP_OUT_FULL && kind_i == acc_ops_pkg::KIND_TC ##1 wr_en_o);
endmodule : accumulator_data_ops
`default_nettype wire

//--- test/ref_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module ref_mem_model (
   input wire logic clk_sys_i,
   input wire logic wr_en_i,
   input wire logic [15:0] wr_data_i,
   input wire logic [1:0] wr_strb_i,
   output logic [7:0] dest_byte_o,
   output logic [15:0] mem_o
);
   // byte strobes pick which half of the reference changes
   always_ff @(posedge clk_sys_i) begin
      if (wr_en_i && wr_strb_i[0])
         mem_o[7:0] <= wr_data_i[7:0];
      if (wr_en_i && wr_strb_i[1])
         mem_o[15:8] <= wr_data_i[15:8];
   end
   // nibble writes merge against what the reference holds now
   assign dest_byte_o = mem_o[7:0];
endmodule : ref_mem_model
`default_nettype wire

//--- test/accumulator_data_ops_tb.sv
`timescale 1ns/100ps
`default_nettype none
module accumulator_data_ops_tb;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic start_i = 1'b0;
   logic [3:0] op_i = 4'h0;
   logic [2:0] kind_i = 3'h0;
   logic [15:0] operand_i = 16'h0000;
   logic [7:0] dest_byte;
   logic [15:0] mem, acc_o, aux_acc_o, wr_data_o;
   logic [1:0] wr_strb_o;
   logic wr_en_o, coil_gt_o, coil_lt_o, coil_eq_o, busy_o, done_o, err_o, err_seen, busy_seen;
   int errors = 0;
   int check_count = 0;
   always #2 clk_sys_i = ~clk_sys_i;
   accumulator_data_ops dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .start_i(start_i),
      .op_i(op_i), .kind_i(kind_i), .operand_i(operand_i), .dest_byte_i(dest_byte),
      .acc_o(acc_o), .aux_acc_o(aux_acc_o), .wr_en_o(wr_en_o), .wr_data_o(wr_data_o),
      .wr_strb_o(wr_strb_o), .coil_gt_o(coil_gt_o), .coil_lt_o(coil_lt_o),
      .coil_eq_o(coil_eq_o), .busy_o(busy_o), .done_o(done_o), .err_o(err_o));
   ref_mem_model mem_model (.clk_sys_i(clk_sys_i), .wr_en_i(wr_en_o), .wr_data_i(wr_data_o),
      .wr_strb_i(wr_strb_o), .dest_byte_o(dest_byte), .mem_o(mem));
   task conclude;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   task chk_w(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: word %h expected %h", $time, g, e);
      end
   endtask : chk_w
   task chk_b(input logic g, input logic e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: flag %b expected %b", $time, g, e);
      end
   endtask : chk_b
   // one request, wait for done, then one more edge so the reference write lands
   task run_op(input logic [3:0] o, input logic [2:0] k, input logic [15:0] v);
      int n;
      @(posedge clk_sys_i);
      start_i <= 1'b1;
      op_i <= o;
      kind_i <= k;
      operand_i <= v;
      @(posedge clk_sys_i);
      start_i <= 1'b0;
      // the take edge launches done for single-cycle ops, so look right after it
      #1;
      busy_seen = busy_o;
      n = 0;
      while (done_o !== 1'b1 && n < 60) begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end
      if (n >= 60) begin
         errors++;
         $display("wrong value at %0t: no done", $time);
      end
      err_seen = err_o;
      @(posedge clk_sys_i);
      #1;
   endtask : run_op
   task t_load;
      run_op(acc_ops_pkg::OP_LOAD_WIDE, acc_ops_pkg::KIND_HD_IN, 16'h1234);
      chk_w(acc_o, 16'h1234);
      run_op(acc_ops_pkg::OP_LOAD_WIDE, acc_ops_pkg::KIND_DR, 16'h5555);
      chk_b(err_seen, 1'b1);
      chk_w(acc_o, 16'h1234);
   endtask : t_load
   task t_out;
      run_op(acc_ops_pkg::OP_OUT_FULL, acc_ops_pkg::KIND_DR, 16'h0000);
      chk_w(mem, 16'h1234);
      run_op(acc_ops_pkg::OP_LOAD_WIDE, acc_ops_pkg::KIND_HD_IN, 16'h56a7);
      run_op(acc_ops_pkg::OP_OUT_FULL, acc_ops_pkg::KIND_HD_IN, 16'h0000);
      chk_b(err_seen, 1'b1);
      run_op(acc_ops_pkg::OP_OUT_BYTE, acc_ops_pkg::KIND_IR, 16'h0000);
      chk_w(mem, 16'h12a7);
   endtask : t_out
   task t_nib;
      run_op(acc_ops_pkg::OP_OUT_HNIB, acc_ops_pkg::KIND_SR, 16'h0000);
      chk_w(mem, 16'h1277);
      run_op(acc_ops_pkg::OP_LOAD_WIDE, acc_ops_pkg::KIND_HD_IN, 16'h0009);
      run_op(acc_ops_pkg::OP_OUT_LNIB, acc_ops_pkg::KIND_OUTPUT, 16'h0000);
      chk_w(mem, 16'h1279);
   endtask : t_nib
   task t_wide;
      run_op(acc_ops_pkg::OP_OUT_WIDE, acc_ops_pkg::KIND_OUTPUT, 16'h0000);
      chk_b(err_seen, 1'b1);
      chk_w(mem, 16'h1279);
      run_op(acc_ops_pkg::OP_OUT_WIDE, acc_ops_pkg::KIND_HD_OUT, 16'h0000);
      chk_w(mem, 16'h0009);
   endtask : t_wide
   task t_cmp;
      run_op(acc_ops_pkg::OP_LOAD_WIDE, acc_ops_pkg::KIND_HD_IN, 16'h0500);
      run_op(acc_ops_pkg::OP_CMP, acc_ops_pkg::KIND_CONST, 16'h0400);
      chk_w({13'h0, coil_gt_o, coil_lt_o, coil_eq_o}, 16'h0004);
      run_op(acc_ops_pkg::OP_CMP, acc_ops_pkg::KIND_DR, 16'h0600);
      chk_w({13'h0, coil_gt_o, coil_lt_o, coil_eq_o}, 16'h0002);
      run_op(acc_ops_pkg::OP_CMP, acc_ops_pkg::KIND_CONST, 16'h0500);
      chk_w({13'h0, coil_gt_o, coil_lt_o, coil_eq_o}, 16'h0001);
   endtask : t_cmp
   // carries and borrows ripple through the three low digits into the top one on purpose
   task t_math;
      run_op(acc_ops_pkg::OP_LOAD_WIDE, acc_ops_pkg::KIND_HD_IN, 16'h0999);
      run_op(acc_ops_pkg::OP_ADD, acc_ops_pkg::KIND_CONST, 16'h0001);
      chk_w(acc_o, 16'h1000);
      run_op(acc_ops_pkg::OP_ADD, acc_ops_pkg::KIND_DR, 16'h00a1);
      chk_b(err_seen, 1'b1);
      run_op(acc_ops_pkg::OP_SUB, acc_ops_pkg::KIND_DR, 16'h0001);
      chk_w(acc_o, 16'h0999);
      chk_b(busy_seen, 1'b0);
      run_op(acc_ops_pkg::OP_LOAD_WIDE, acc_ops_pkg::KIND_HD_IN, 16'h1234);
      run_op(acc_ops_pkg::OP_MUL, acc_ops_pkg::KIND_CONST, 16'h5678);
      chk_w(acc_o, 16'h6652);
      chk_w(aux_acc_o, 16'h0700);
      chk_b(busy_seen, 1'b1);
      run_op(acc_ops_pkg::OP_SUB, acc_ops_pkg::KIND_CONST, 16'h9000);
      chk_b(err_seen, 1'b1);
      chk_w(acc_o, 16'h7652);
      run_op(acc_ops_pkg::OP_ADD, acc_ops_pkg::KIND_CONST, 16'h5000);
      chk_b(err_seen, 1'b1);
      chk_w(acc_o, 16'h2652);
      run_op(4'hf, acc_ops_pkg::KIND_CONST, 16'h0000);
      chk_b(err_seen, 1'b1);
      chk_w(acc_o, 16'h2652);
      run_op(acc_ops_pkg::OP_OUT_FULL, acc_ops_pkg::KIND_TC, 16'h0000);
      chk_b(err_seen, 1'b0);
      chk_w(mem, 16'h2652);
   endtask : t_math
   initial begin
      #20000;
      errors++;
      conclude();
   end
   initial begin
      repeat (2) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      t_load();
      t_out();
      t_nib();
      t_wide();
      t_cmp();
      t_math();
      conclude();
   end
endmodule : accumulator_data_ops_tb
`default_nettype wire
